// file: src/rpcfg_params.svh
/*
 Register offsets, reset values and timing counts for the retry,
 link-session and PHY configuration register slice.
 Assumes a 40 MHz system clock and byte-wide register addressing.
*/
`ifndef RPCFG_PARAMS_SVH
`define RPCFG_PARAMS_SVH

// Register byte offsets
`define RPCFG_OFS_RETRY_COUNT 16'h001B
`define RPCFG_OFS_ECHO_INTERVAL 16'h001C
`define RPCFG_OFS_ECHO_MAGIC 16'h001D
`define RPCFG_OFS_SERVER_HW_FIRST 16'h001E
`define RPCFG_OFS_SERVER_HW_LAST 16'h0023
`define RPCFG_OFS_SESSION_ID_HI 16'h0024
`define RPCFG_OFS_SESSION_ID_LO 16'h0025
`define RPCFG_OFS_MRU_HI 16'h0026
`define RPCFG_OFS_MRU_LO 16'h0027
`define RPCFG_OFS_UNREACHABLE_FLAG_IP_FIRST 16'h0028
`define RPCFG_OFS_UNREACHABLE_FLAG_IP_LAST 16'h002B
`define RPCFG_OFS_UNREACHABLE_FLAG_PORT_HI 16'h002C
`define RPCFG_OFS_UNREACHABLE_FLAG_PORT_LO 16'h002D
`define RPCFG_OFS_PHY_CFG 16'h002E
`define RPCFG_OFS_VERSION 16'h0039
`define RPCFG_OFS_COMMON_FLAGS 16'h0015

// Field positions
`define RPCFG_PHY_RST_BIT 7
`define RPCFG_PHY_SRC_BIT 6
`define RPCFG_PHY_MODE_HI 5
`define RPCFG_PHY_MODE_LO 3
`define RPCFG_PHY_DPX_BIT 2
`define RPCFG_PHY_SPD_BIT 1
`define RPCFG_PHY_LNK_BIT 0
`define RPCFG_UNREACHABLE_FLAG_BIT 6

// Reset values
`define RPCFG_RST_RETRY_COUNT 8'h08
`define RPCFG_RST_ECHO_INTERVAL 8'h28
`define RPCFG_RST_ECHO_MAGIC 8'h00
`define RPCFG_RST_SERVER_HW 48'h000000000000
`define RPCFG_RST_SESSION_ID 16'h0000
`define RPCFG_RST_MRU 16'hFFFF
`define RPCFG_RST_UNREACHABLE_FLAG_IP 32'h00000000
`define RPCFG_RST_UNREACHABLE_FLAG_PORT 16'h0000
`define RPCFG_RST_PHY_RST 1'b1
`define RPCFG_RST_PHY_SRC 1'b0
`define RPCFG_RST_PHY_MODE 3'h7

// Timing: clock period, retry-time unit and echo unit
`define RPCFG_CLK_PERIOD_NS 25
`define RPCFG_RETRY_UNIT_NS 100000
`define RPCFG_TICK_CYCLES (`RPCFG_RETRY_UNIT_NS / `RPCFG_CLK_PERIOD_NS)
`define RPCFG_ECHO_UNIT_MS 25
`define RPCFG_ECHO_UNIT_TICKS (`RPCFG_ECHO_UNIT_MS * 1000000 / `RPCFG_RETRY_UNIT_NS)
`define RPCFG_WAIT_MAX 17'h0FFFF
`define RPCFG_SOCKETS 8

`endif

// file: src/rpcfg_pkg.sv
/*
 Types for the retry, link-session and PHY configuration slice.
 Assumes the constants header is on the include path.
*/
`include "rpcfg_params.svh"
package rpcfg_pkg;
  // Whole state of the register slice, registered in one process
  typedef struct packed {
    logic [7:0] retryCount;
    logic [7:0] echoInterval;
    logic [7:0] echoMagicByte;
    logic [47:0] serverHw;
    logic [15:0] sessionId;
    logic [15:0] maxRecvUnit;
    logic [31:0] unreachIp;
    logic [15:0] unreachPort;
    logic unreachFlag;
    logic phyRst;
    logic modeSrc;
    logic [2:0] modeField;
    logic [2:0] phyMode;
    logic [7:0] rdData;
    logic [11:0] tickCnt;
    logic tick;
    logic [15:0] echoSub;
    logic [7:0] echoUnits;
    logic echoPulse;
    logic [`RPCFG_SOCKETS-1:0] active;
    logic [`RPCFG_SOCKETS-1:0] isTcp;
    logic [`RPCFG_SOCKETS-1:0] retx;
    logic [`RPCFG_SOCKETS-1:0] tmo;
    logic [`RPCFG_SOCKETS-1:0][7:0] tries;
    logic [`RPCFG_SOCKETS-1:0][15:0] waitLeft;
    logic [`RPCFG_SOCKETS-1:0][15:0] waitLen;
  } rpcfg_state_type;
endpackage

// file: src/rpcfg_regs.sv
/*
 Retry timing engine, link-session echo timer, unreachable capture and
 PHY configuration/status register slice, reached by byte-wide register
 strobes behind the serial host port.
 Assumes the serial frame decoder gives one-cycle read/write strobes,
 socket logic reports starts and answers per socket, and all inputs are
 synchronous to clk.
*/
`timescale 1ns/10ps
`include "rpcfg_params.svh"
module rpcfg_regs
#(
  // Echo unit in 100 us ticks; shorten for simulation
  parameter int ECHO_UNIT_TICKS = `RPCFG_ECHO_UNIT_TICKS,
  // Version code returned by the read-only register; value is arbitrary
  parameter logic [7:0] CHIP_VERSION = 8'h5A
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic [15:0] retryTime,
  input wire logic [`RPCFG_SOCKETS-1:0] sockStart,
  input wire logic [`RPCFG_SOCKETS-1:0] sockIsTcp,
  input wire logic [`RPCFG_SOCKETS-1:0] sockAnswer,
  output logic [`RPCFG_SOCKETS-1:0] sockRetransmit,
  output logic [`RPCFG_SOCKETS-1:0] sockTimeout,
  input wire logic echoEnable,
  output logic echoRequest,
  output logic [31:0] echoMagic,
  output logic [47:0] sessionServerHw,
  output logic [15:0] sessionIdentifier,
  output logic [15:0] sessionMaxRecvUnit,
  input wire logic unreachValid,
  input wire logic [31:0] unreachIpIn,
  input wire logic [15:0] unreachPortIn,
  output logic unreachableFlag,
  input wire logic [2:0] phyModePins,
  input wire logic duplexFlag,
  input wire logic speedFlag,
  input wire logic linkUpFlag,
  output logic phyResetN,
  output logic [2:0] phyMode
);
  ////////////////////////////////////////////////////////////////////////
  // State and helpers
  rpcfg_pkg::rpcfg_state_type state_ff; // Registered state
  rpcfg_pkg::rpcfg_state_type nxt_state; // Next state
  // Offset match for one address, used by the single-offset registers on read and write
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction
  // Read-back PHY configuration byte, status bits taken live
  function automatic logic [7:0] phyCfgByte(
    input rpcfg_pkg::rpcfg_state_type s,
    input logic duplex_flag,
    input logic speed_flag,
    input logic link_up_flag);
    phyCfgByte = {s.phyRst, s.modeSrc, s.modeField, duplex_flag, speed_flag, link_up_flag};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [16:0] doubled;
    logic [15:0] rtmp;
    doubled = 17'h00000;
    rtmp = 16'h0000;
    nxt_state = state_ff;
    // Register writes; read-only offsets are not decoded here
    if (regWrEn)
    begin
      if (hit(regAddr, `RPCFG_OFS_RETRY_COUNT))
      begin
        nxt_state.retryCount = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_ECHO_INTERVAL))
      begin
        nxt_state.echoInterval = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_ECHO_MAGIC))
      begin
        nxt_state.echoMagicByte = regWrData;
      end
      else if (regAddr >= `RPCFG_OFS_SERVER_HW_FIRST &&
               regAddr <= `RPCFG_OFS_SERVER_HW_LAST)
      begin
        // First offset is the most significant byte
        rtmp = `RPCFG_OFS_SERVER_HW_LAST - regAddr;
        nxt_state.serverHw[rtmp[2:0]*8 +: 8] = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_SESSION_ID_HI))
      begin
        nxt_state.sessionId[15:8] = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_SESSION_ID_LO))
      begin
        nxt_state.sessionId[7:0] = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_MRU_HI))
      begin
        nxt_state.maxRecvUnit[15:8] = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_MRU_LO))
      begin
        nxt_state.maxRecvUnit[7:0] = regWrData;
      end
      else if (hit(regAddr, `RPCFG_OFS_PHY_CFG))
      begin
        // Status bits are read-only; writes only reach bits 7..3
        nxt_state.phyRst = regWrData[`RPCFG_PHY_RST_BIT];
        nxt_state.modeSrc = regWrData[`RPCFG_PHY_SRC_BIT];
        nxt_state.modeField =
          regWrData[`RPCFG_PHY_MODE_HI:`RPCFG_PHY_MODE_LO];
      end
      else if (hit(regAddr, `RPCFG_OFS_COMMON_FLAGS))
      begin
        // Write-one clears; a same-cycle event re-sets below
        if (regWrData[`RPCFG_UNREACHABLE_FLAG_BIT])
        begin
          nxt_state.unreachFlag = 1'b0;
        end
      end
      // Version and capture offsets ignore writes
    end
    // Unreachable capture; set wins over a host clear
    if (unreachValid)
    begin
      nxt_state.unreachFlag = 1'b1;
      nxt_state.unreachIp = unreachIpIn;
      nxt_state.unreachPort = unreachPortIn;
    end
    // Effective PHY mode: register field or pins
    nxt_state.phyMode = state_ff.modeSrc ? state_ff.modeField : phyModePins;
    // Register reads, answered one cycle later; unmapped reads give zero
    nxt_state.rdData = 8'h00;
    if (regRdEn)
    begin
      if (hit(regAddr, `RPCFG_OFS_RETRY_COUNT))
      begin
        nxt_state.rdData = state_ff.retryCount;
      end
      else if (hit(regAddr, `RPCFG_OFS_ECHO_INTERVAL))
      begin
        nxt_state.rdData = state_ff.echoInterval;
      end
      else if (hit(regAddr, `RPCFG_OFS_ECHO_MAGIC))
      begin
        nxt_state.rdData = state_ff.echoMagicByte;
      end
      else if (regAddr >= `RPCFG_OFS_SERVER_HW_FIRST &&
               regAddr <= `RPCFG_OFS_SERVER_HW_LAST)
      begin
        rtmp = `RPCFG_OFS_SERVER_HW_LAST - regAddr;
        nxt_state.rdData = state_ff.serverHw[rtmp[2:0]*8 +: 8];
      end
      else if (hit(regAddr, `RPCFG_OFS_SESSION_ID_HI))
      begin
        nxt_state.rdData = state_ff.sessionId[15:8];
      end
      else if (hit(regAddr, `RPCFG_OFS_SESSION_ID_LO))
      begin
        nxt_state.rdData = state_ff.sessionId[7:0];
      end
      else if (hit(regAddr, `RPCFG_OFS_MRU_HI))
      begin
        nxt_state.rdData = state_ff.maxRecvUnit[15:8];
      end
      else if (hit(regAddr, `RPCFG_OFS_MRU_LO))
      begin
        nxt_state.rdData = state_ff.maxRecvUnit[7:0];
      end
      else if (regAddr >= `RPCFG_OFS_UNREACHABLE_FLAG_IP_FIRST &&
               regAddr <= `RPCFG_OFS_UNREACHABLE_FLAG_IP_LAST)
      begin
        rtmp = `RPCFG_OFS_UNREACHABLE_FLAG_IP_LAST - regAddr;
        nxt_state.rdData = state_ff.unreachIp[rtmp[1:0]*8 +: 8];
      end
      else if (hit(regAddr, `RPCFG_OFS_UNREACHABLE_FLAG_PORT_HI))
      begin
        nxt_state.rdData = state_ff.unreachPort[15:8];
      end
      else if (hit(regAddr, `RPCFG_OFS_UNREACHABLE_FLAG_PORT_LO))
      begin
        nxt_state.rdData = state_ff.unreachPort[7:0];
      end
      else if (hit(regAddr, `RPCFG_OFS_PHY_CFG))
      begin
        nxt_state.rdData =
          phyCfgByte(state_ff, duplexFlag, speedFlag, linkUpFlag);
      end
      else if (hit(regAddr, `RPCFG_OFS_VERSION))
      begin
        nxt_state.rdData = CHIP_VERSION;
      end
      else if (hit(regAddr, `RPCFG_OFS_COMMON_FLAGS))
      begin
        nxt_state.rdData = {1'b0, state_ff.unreachFlag, 6'h00};
      end
    end

    // 100 us tick prescaler for all retry waits
    nxt_state.tick = 1'b0;
    if (state_ff.tickCnt == 12'(`RPCFG_TICK_CYCLES - 1))
    begin
      nxt_state.tickCnt = 12'h000;
      nxt_state.tick = 1'b1;
    end
    else
    begin
      nxt_state.tickCnt = state_ff.tickCnt + 12'h001;
    end

    // Echo timer in 25 ms units; an interval of zero sends nothing
    nxt_state.echoPulse = 1'b0;
    if (!echoEnable || state_ff.echoInterval == 8'h00)
    begin
      nxt_state.echoSub = 16'h0000;
      nxt_state.echoUnits = 8'h00;
    end
    else if (state_ff.tick)
    begin
      if (state_ff.echoSub == 16'(ECHO_UNIT_TICKS - 1))
      begin
        nxt_state.echoSub = 16'h0000;
        if (state_ff.echoUnits + 8'h01 >= state_ff.echoInterval)
        begin
          nxt_state.echoUnits = 8'h00;
          nxt_state.echoPulse = 1'b1;
        end
        else
        begin
          nxt_state.echoUnits = state_ff.echoUnits + 8'h01;
        end
      end
      else
      begin
        nxt_state.echoSub = state_ff.echoSub + 16'h0001;
      end
    end

    // Per-socket retry engines; answers take priority over starts
    nxt_state.retx = '0;
    nxt_state.tmo = '0;
    for (int s = 0; s < `RPCFG_SOCKETS; s++)
    begin
      doubled = {state_ff.waitLen[s], 1'b0};
      if (sockAnswer[s])
      begin
        // Valid reply or acknowledgement ends the sequence
        nxt_state.active[s] = 1'b0;
        nxt_state.tries[s] = 8'h00;
      end
      else if (sockStart[s])
      begin
        // First wait is one retry-time period
        nxt_state.active[s] = 1'b1;
        nxt_state.isTcp[s] = sockIsTcp[s];
        nxt_state.tries[s] = 8'h00;
        nxt_state.waitLen[s] = retryTime;
        nxt_state.waitLeft[s] = retryTime;
      end
      else if (state_ff.active[s] && state_ff.tick)
      begin
        if (state_ff.waitLeft[s] <= 16'h0001)
        begin
          if (state_ff.tries[s] == state_ff.retryCount)
          begin
            // retry-count plus one waits spent: final timeout
            nxt_state.tmo[s] = 1'b1;
            nxt_state.active[s] = 1'b0;
            nxt_state.tries[s] = 8'h00;
          end
          else
          begin
            // Temporary timeout: resend and wait again
            nxt_state.retx[s] = 1'b1;
            nxt_state.tries[s] = state_ff.tries[s] + 8'h01;
            if (state_ff.isTcp[s] && doubled <= `RPCFG_WAIT_MAX)
            begin
              // Double until it would pass the cap, then hold
              nxt_state.waitLen[s] = doubled[15:0];
              nxt_state.waitLeft[s] = doubled[15:0];
            end
            else
            begin
              nxt_state.waitLeft[s] = state_ff.waitLen[s];
            end
          end
        end
        else
        begin
          nxt_state.waitLeft[s] = state_ff.waitLeft[s] - 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Reset values; PHY mode follows pins after reset
      state_ff <= '0;
      state_ff.retryCount <= `RPCFG_RST_RETRY_COUNT;
      state_ff.echoInterval <= `RPCFG_RST_ECHO_INTERVAL;
      state_ff.echoMagicByte <= `RPCFG_RST_ECHO_MAGIC;
      state_ff.serverHw <= `RPCFG_RST_SERVER_HW;
      state_ff.sessionId <= `RPCFG_RST_SESSION_ID;
      state_ff.maxRecvUnit <= `RPCFG_RST_MRU;
      state_ff.unreachIp <= `RPCFG_RST_UNREACHABLE_FLAG_IP;
      state_ff.unreachPort <= `RPCFG_RST_UNREACHABLE_FLAG_PORT;
      state_ff.phyRst <= `RPCFG_RST_PHY_RST;
      state_ff.modeSrc <= `RPCFG_RST_PHY_SRC;
      state_ff.modeField <= `RPCFG_RST_PHY_MODE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign regRdData = state_ff.rdData;
  assign sockRetransmit = state_ff.retx;
  assign sockTimeout = state_ff.tmo;
  assign echoRequest = state_ff.echoPulse;
  assign echoMagic = {4{state_ff.echoMagicByte}};
  assign sessionServerHw = state_ff.serverHw;
  assign sessionIdentifier = state_ff.sessionId;
  assign sessionMaxRecvUnit = state_ff.maxRecvUnit;
  assign unreachableFlag = state_ff.unreachFlag;
  assign phyResetN = state_ff.phyRst;
  // Mode lags a source change by one cycle; harmless as PHY needs reset
  assign phyMode = state_ff.phyMode;
endmodule // rpcfg_regs

// file: verif/rpcfg_regs_properties.sv
/*
 Checker for the retry, session and PHY register slice.
 Assumes it is bound to rpcfg_regs and sees only that module's ports.
*/
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module rpcfg_regs_chk
#(
  parameter logic [7:0] CHIP_VERSION = 8'h5A
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] sockRetransmit,
  input wire logic [7:0] sockTimeout,
  input wire logic echoEnable,
  input wire logic echoRequest,
  input wire logic [31:0] echoMagic,
  input wire logic unreachValid,
  input wire logic unreachableFlag,
  input wire logic duplexFlag,
  input wire logic speedFlag,
  input wire logic linkUpFlag,
  input wire logic phyResetN
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Host writing one to the unreachable flag bit
  logic clrHit;
  assign clrHit = regWrEn && regAddr == 16'h0015 && regWrData[6];
  ////////////////////////////////////////////////////////////
  chk_read_idle: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data not idle");
  chk_ver_read: assert property (regRdEn && regAddr == 16'h0039
    |=> regRdData == CHIP_VERSION) else $error("version wrong");
  chk_phy_live: assert property (regRdEn && regAddr == 16'h002E
    |=> regRdData[2:0] == $past({duplexFlag, speedFlag, linkUpFlag}))
    else $error("phy status wrong");
  chk_phy_hold: assert property (regWrEn && regAddr == 16'h002E
    && !regWrData[7] |=> !phyResetN) else $error("phy not reset");
  chk_unreachable_flag_set: assert property (unreachValid |=> unreachableFlag)
    else $error("unreachable flag not set");
  chk_unreachable_flag_clr: assert property (clrHit && !unreachValid
    |=> !unreachableFlag) else $error("unreachable flag not cleared");
  chk_flag_hold: assert property (unreachableFlag && !clrHit
    |=> unreachableFlag) else $error("unreachable flag lost");
  chk_magic_rep: assert property (regWrEn && regAddr == 16'h001D
    |=> echoMagic == {4{$past(regWrData)}})
    else $error("magic not repeated");
  chk_echo_gate: assert property (!echoEnable ##1 !echoEnable
    |-> !echoRequest) else $error("echo while disabled");
  chk_one_kind: assert property (!(|(sockRetransmit & sockTimeout)))
    else $error("resend and timeout together");
  // Main scenarios reached
  cov_echo: cover property (echoRequest);
  cov_tmo: cover property (sockTimeout != 8'h00);
  cov_clr: cover property (unreachableFlag && clrHit);
endmodule // rpcfg_regs_chk

bind rpcfg_regs rpcfg_regs_chk #(.CHIP_VERSION(CHIP_VERSION)) u_chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .sockRetransmit(sockRetransmit), .sockTimeout(sockTimeout),
  .echoEnable(echoEnable), .echoRequest(echoRequest),
  .echoMagic(echoMagic), .unreachValid(unreachValid),
  .unreachableFlag(unreachableFlag), .duplexFlag(duplexFlag),
  .speedFlag(speedFlag), .linkUpFlag(linkUpFlag), .phyResetN(phyResetN));

// file: verif/rpcfg_host_model.sv
/*
 Host model: byte-wide register strobes as the serial decoder gives them.
 Assumes the bench calls its tasks; strobes change at falling edges.
*/
`timescale 1ns/10ps
module rpcfg_host_model
(
  input wire logic clk,
  output logic [15:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  // Idle bus at time zero
  initial
  begin
    regAddr = 16'hFFFF;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // One write strobe; released lines show inverted values, not stale ones
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    regWrData = ~d;
    regAddr = ~a;
  endtask
  // One read strobe; the byte is taken while it stands
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
  // Server address then session id, most significant byte first
  task automatic session_setup(input logic [47:0] hw, input logic [15:0] id);
    logic [63:0] b;
    b = {hw, id};
    for (int i = 0; i < 8; i++)
      wr(16'h001E + 16'(i), b[63-8*i -: 8]);
  endtask
  // Mode change: source and field first, then a reset pulse
  task automatic phy_select(input logic [2:0] m);
    wr(16'h002E, {2'b11, m, 3'b000});
    wr(16'h002E, {2'b01, m, 3'b000});
    wr(16'h002E, {2'b11, m, 3'b000});
  endtask
endmodule // rpcfg_host_model

// file: verif/tb.sv
/*
 Self-checking bench for the retry, session and PHY register slice.
 Assumes the host model drives the register strobes; 40 MHz clock.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] VER = 8'h3C; // Version code, arbitrary
  logic clk = 1'b0;
  logic rst_n, regWrEn, regRdEn, echoEnable, echoRequest, unreachValid;
  logic unreachableFlag, duplexFlag, speedFlag, linkUpFlag, phyResetN;
  logic [15:0] regAddr, retryTime, unreachPortIn, sessionIdentifier;
  logic [15:0] sessionMaxRecvUnit;
  logic [7:0] regWrData, regRdData, sockStart, sockIsTcp, sockAnswer;
  logic [7:0] sockRetransmit, sockTimeout, d;
  logic [31:0] echoMagic, unreachIpIn, ip, pt, seed = 32'hFFD76D12;
  logic [47:0] sessionServerHw, hw;
  logic [2:0] phyModePins, phyMode;
  logic [15:0] a;
  logic [7:0] v [13];
  logic [3:0] ev;
  int miscompares = 0, cmp_count = 0, m, cyc, s, k;
  int n[4], last[4], tmoIdx[3], gap[4][3];
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  rpcfg_regs #(.ECHO_UNIT_TICKS(2), .CHIP_VERSION(VER)) dut (.clk(clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .retryTime(retryTime), .sockStart(sockStart), .sockIsTcp(sockIsTcp),
    .sockAnswer(sockAnswer), .sockRetransmit(sockRetransmit),
    .sockTimeout(sockTimeout), .echoEnable(echoEnable),
    .echoRequest(echoRequest), .echoMagic(echoMagic),
    .sessionServerHw(sessionServerHw),
    .sessionIdentifier(sessionIdentifier),
    .sessionMaxRecvUnit(sessionMaxRecvUnit), .unreachValid(unreachValid),
    .unreachIpIn(unreachIpIn), .unreachPortIn(unreachPortIn),
    .unreachableFlag(unreachableFlag), .phyModePins(phyModePins),
    .duplexFlag(duplexFlag), .speedFlag(speedFlag),
    .linkUpFlag(linkUpFlag), .phyResetN(phyResetN), .phyMode(phyMode));
  rpcfg_host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  ////////////////////////////////////////////////////////////
  // Xorshift source, fixed seed so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Byte expected at reset; live status comes from the bench's flags
  function automatic logic [7:0] exp_rst(input logic [15:0] ad);
    case (ad)
      16'h001B: return 8'h08;
      16'h001C: return 8'h28;
      16'h0026, 16'h0027: return 8'hFF;
      16'h002E: return {5'b10111, duplexFlag, speedFlag, linkUpFlag};
      16'h0039: return VER;
      default: return 8'h00;
    endcase
  endfunction
  // Cycles between pulses k-1 and k; TCP doubles unless over 65535
  function automatic int exp_gap(input int tcp, input int rt, input int kk);
    int w;
    w = rt;
    for (int i = 0; i < kk; i++)
      if (tcp != 0 && w * 2 <= 65535)
        w = w * 2;
    return w * 4000;
  endfunction
  task automatic chk_val(input string nm, input logic [47:0] e,
    input logic [47:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e)
    begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang counts against the run
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    retryTime = 16'h0001;
    {sockStart, sockIsTcp, sockAnswer} = 24'h000000;
    {echoEnable, unreachValid, unreachIpIn, unreachPortIn} = '0;
    {phyModePins, duplexFlag, speedFlag, linkUpFlag} = 6'h2D;
    n = '{4{0}};
    last = '{4{0}};
    tmoIdx = '{3{-1}};
    gap = '{4{'{3{0}}}};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    // Reset image, unmapped gap included, status varied per read
    for (a = 16'h001B; a <= 16'h0039; a++)
    begin
      {duplexFlag, speedFlag, linkUpFlag} = 3'(rnd());
      host.rd(a, d);
      chk_val("reset byte", exp_rst(a), d);
    end
    // Random writes, session setup, then read-only bytes poked
    for (a = 16'h001B; a <= 16'h0027; a++)
    begin
      v[a-16'h001B] = 8'(rnd());
      host.wr(a, v[a-16'h001B]);
    end
    hw = 48'({rnd(), rnd()});
    pt = rnd();
    host.session_setup(hw, pt[15:0]);
    {v[3], v[4], v[5], v[6], v[7], v[8], v[9], v[10]} = {hw, pt[15:0]};
    host.wr(16'h0028, 8'hA5);
    host.wr(16'h002D, 8'h5A);
    host.wr(16'h0039, 8'hC3);
    for (a = 16'h001B; a <= 16'h002D; a++)
    begin
      host.rd(a, d);
      chk_val("rw byte", a < 16'h0028 ? v[a-16'h001B] : 8'h00, d);
    end
    host.rd(16'h0039, d);
    chk_val("version", VER, d);
    chk_val("magic", {4{v[2]}}, echoMagic);
    chk_val("server hw", hw, sessionServerHw);
    chk_val("session id", {v[9], v[10]}, sessionIdentifier);
    chk_val("mru", {v[11], v[12]}, sessionMaxRecvUnit);
    // Unreachable message: capture, flag, write-one clear
    ip = rnd();
    pt = rnd();
    @(negedge clk);
    {unreachIpIn, unreachPortIn, unreachValid} = {ip, pt[15:0], 1'b1};
    @(negedge clk);
    {unreachIpIn, unreachValid} = {~ip, 1'b0};
    chk_val("unreachable_flag flag", 1, unreachableFlag);
    for (a = 16'h0028; a <= 16'h002D; a++)
    begin
      host.rd(a, d);
      chk_val("unreachable_flag", 8'({ip, pt[15:0]} >> (8*(16'h002D-a))), d);
    end
    host.rd(16'h0015, d);
    chk_val("event flags", 8'h40, d);
    host.wr(16'h0015, 8'h40);
    chk_val("unreachable_flag flag", 0, unreachableFlag);
    // Message and host clear in one cycle: the set must win
    fork
      host.wr(16'h0015, 8'h40);
      begin
        @(negedge clk);
        unreachValid = 1'b1;
        @(negedge clk);
        unreachValid = 1'b0;
      end
    join
    chk_val("set wins", 1, unreachableFlag);
    // Every register mode, then back to the pins
    for (m = 0; m < 8; m++)
    begin
      host.phy_select(3'(m));
      chk_val("phy mode", m, phyMode);
      chk_val("phy reset", 1, phyResetN);
    end
    phyModePins = 3'(rnd());
    host.wr(16'h002E, 8'hB8);
    @(negedge clk);
    chk_val("pin mode", phyModePins, phyMode);
    // Retry engine: ARP, TCP, answered socket; echo timer alongside
    host.wr(16'h001B, 8'h02);
    host.wr(16'h001C, 8'h01);
    @(negedge clk);
    {sockIsTcp, sockStart, echoEnable} = {8'h02, 8'h07, 1'b1};
    @(negedge clk);
    {sockStart, sockAnswer} = {8'h00, 8'h04};
    @(negedge clk);
    sockAnswer = 8'h00;
    for (cyc = 0; cyc < 30000; cyc++)
    begin
      @(negedge clk);
      ev = {echoRequest, sockRetransmit[2:0] | sockTimeout[2:0]};
      for (s = 0; s < 4; s++)
        if (ev[s])
        begin
          if (n[s] > 0 && n[s] < 3)
            gap[s][n[s]] = cyc - last[s];
          if (s < 3 && sockTimeout[s])
            tmoIdx[s] = n[s];
          n[s]++;
          last[s] = cyc;
        end
    end
    for (s = 0; s < 2; s++)
    begin
      chk_cnt("pulses", 3, n[s]);
      chk_cnt("final at", 2, tmoIdx[s]);
      for (k = 1; k < 3; k++)
        chk_cnt("gap", exp_gap(s, 1, k), gap[s][k]);
    end
    chk_cnt("answered", 0, n[2]);
    chk_cnt("echo gap", 8000, gap[3][1]);
    chk_cnt("echo gap", 8000, gap[3][2]);
    end_sim;
  end
endmodule // tb
